// [inc/tbc_pkg.sv]
// timer control block: constants, register map and control-word layout
// assumes a 32-bit Avalon-MM slave port with byte addresses, registers in the low 16 bits of each word
//
// Summary of operation
// - control register clears to all zeros on every reset
// - capture mode with trigger enabled: falling trigger edge captures the count
// - reload mode: reload on overflow, and on falling trigger edge when enabled with down-count and PWM clear
// - outside PWM, every overflow or underflow is followed by an automatic reload
// - with interrupt enable set, overflow flag outside clock-output mode, or trigger flag outside pin-directed up/down reload mode, requests an interrupt
// - clock-output mode still sets overflow flag but never interrupts from it
// - count advances only while run is set; with run clear only a trigger reload or a write moves it
// - up-count reload from an enabled trigger edge sets the count to zero
// - trigger enable clear: trigger input ignored for capture and reload
// - reload mode with PWM and trigger enabled: PWM falling edges set trigger flag
// - down-count enable clear: counter counts upward only
// - down-count enable set outside PWM: count up while input high, down while low
// - PWM with up/down counting: direction chosen internally from count and top
// - compare modes: down-count clear counts up and resets, set counts up then down
// - outside pin-directed up/down reload mode, trigger flag stays set until software clears it; writing one forces interrupt
// - clock output enable with PWM clear drives a clock on the output pin, rollovers raise no timer request

package tbc_pkg;

	localparam int TBC_ADDR_W = 8;
	localparam int TBC_DATA_W = 32;

	// register word indices; byte address is four times the index
	localparam logic [5:0] TBC_IDX_CTRL = 6'h0A;
	localparam logic [5:0] TBC_IDX_COUNT = 6'h0B;
	localparam logic [5:0] TBC_IDX_RELOAD = 6'h0C;
	localparam logic [5:0] TBC_IDX_CAPTURE = 6'h0D;
	localparam logic [5:0] TBC_IDX_COMPARE = 6'h0E;
	localparam logic [5:0] TBC_IDX_IRQ_STATUS = 6'h0F;
	localparam logic [5:0] TBC_IDX_IRQ_ENABLE = 6'h10;
	localparam logic [5:0] TBC_IDX_IRQ_CLEAR = 6'h11;

	localparam logic [15:0] TBC_CTRL_RST = 16'h0000;
	localparam logic [15:0] TBC_CTRL_WMASK = 16'h0FFF;
	localparam logic [15:0] TBC_COUNT_RST = 16'h0000;
	localparam logic [15:0] TBC_RELOAD_RST = 16'h0000;
	localparam logic [15:0] TBC_COMPARE_RST = 16'h0000;
	localparam logic [15:0] TBC_COUNT_TOP = 16'hFFFF;
	localparam logic [15:0] TBC_COUNT_ZERO = 16'h0000;
	localparam logic [31:0] TBC_UNMAPPED_RD = 32'h0000_0000;

	// interrupt status layout
	localparam int TBC_IRQ_W = 3;
	localparam int TBC_IRQ_TIMER = 0;
	localparam int TBC_IRQ_CAPTURE = 1;
	localparam int TBC_IRQ_WRAP = 2;
	localparam logic [TBC_IRQ_W-1:0] TBC_IRQ_RST = 3'h0;

	localparam int TBC_PS_W = 14;

	typedef struct packed {
		logic [3:0] reserved;
		logic pwm_enable;
		logic [2:0] prescale_sel;
		logic overflow_flag;
		logic external_trigger_flag;
		logic clock_output_enable;
		logic down_count_enable;
		logic external_trigger_enable;
		logic timer_run;
		logic timer_irq_enable;
		logic capture_reload_select;
	} tbc_ctrl_s;

	typedef struct packed {
		logic [TBC_ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [3:0] byteenable;
		logic [TBC_DATA_W-1:0] writedata;
	} tbc_avs_req_s;

endpackage

// [src/tbc_prescale.sv]
// tbc_prescale: divides mclk by 4**sel and emits one-cycle count ticks
// assumes sel is changed only while run is low
`timescale 1ns/1ps

module tbc_prescale
	import tbc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [TBC_PS_W-1:0] ps_cnt_r;

	function automatic logic [TBC_PS_W-1:0] ps_limit(input logic [2:0] s);
		ps_limit = TBC_PS_W'((32'h1 << {s, 1'b0}) - 32'h1);
	endfunction

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ps_cnt_r <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			ps_cnt_r <= '0;
			tick <= 1'b0;
		end else if (ps_cnt_r >= ps_limit(sel)) begin
			ps_cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			ps_cnt_r <= ps_cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end

	tick_rate_a: assert property (@(posedge mclk) disable iff (rst)
		(run && sel == 3'h0 && ps_cnt_r == '0) |=> tick)
		else $error("prescaler missed a tick at divide by one");
endmodule

// [src/tbc_sync.sv]
// tbc_sync: two-flop synchroniser for asynchronous pin levels
// assumes the input is a slow level from outside the mclk domain
`timescale 1ns/1ps

module tbc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;

	// meta_r feeds only sync_out
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// [src/tbc_timer.sv]
// tbc_timer: 16-bit general-purpose timer with capture, autoreload, up/down and PWM/compare
// assumes an Avalon-MM master on mclk; trigger_direction_input is an asynchronous pin
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps

module tbc_timer (
	input wire logic mclk,
	input wire logic rst,
	input wire tbc_pkg::tbc_avs_req_s avs_req,
	output logic [tbc_pkg::TBC_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic trigger_direction_input,
	output logic timer_output_pin,
	output logic timer_output_pin_oe,
	output logic irq
);
	import tbc_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	tbc_ctrl_s ctrl_r, ctrl_nxt;
	logic [15:0] count_r, count_nxt;
	logic [15:0] reload_r, capture_r, compare_r;
	logic [TBC_IRQ_W-1:0] irq_status_r, irq_status_nxt, irq_enable_r;
	logic pwm_dir_r, pwm_dir_nxt;
	logic pin_r, pin_nxt;
	logic trig_s, trig_d_r, ext_fall, tick, wrap;
	logic [5:0] idx;
	logic bus_wr, ctrl_wr, cnt_wr;
	logic ext_capture, ext_reload, pwm_fall, bit17_mode, tmr_req, dir_up, ext_set;
	logic [15:0] top;

	function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		be_merge[7:0] = be[0] ? wd[7:0] : old[7:0];
		be_merge[15:8] = be[1] ? wd[15:8] : old[15:8];
	endfunction

	// ------------------------------------------------------------
	// trigger pin and prescaler
	// ------------------------------------------------------------
	tbc_sync #(.WIDTH(1)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.async_in(trigger_direction_input),
		.sync_out(trig_s)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			trig_d_r <= 1'b0;
		end else begin
			trig_d_r <= trig_s;
		end
	end

	assign ext_fall = trig_d_r & ~trig_s;

	tbc_prescale u_prescale (
		.mclk(mclk),
		.rst(rst),
		.run(ctrl_r.timer_run),
		.sel(ctrl_r.prescale_sel),
		.tick(tick)
	);

	// ------------------------------------------------------------
	// bus slave: one wait cycle, then the access completes
	// ------------------------------------------------------------
	assign idx = avs_req.address[7:2];
	assign bus_wr = avs_req.write & ~avs_waitrequest;
	assign ctrl_wr = bus_wr && idx == TBC_IDX_CTRL;
	assign cnt_wr = bus_wr && idx == TBC_IDX_COUNT;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_req.read | avs_req.write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// read data is latched in the wait cycle and stands at the completing edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_readdata <= TBC_UNMAPPED_RD;
		end else if (avs_req.read && avs_waitrequest) begin
			if (idx == TBC_IDX_CTRL) begin
				avs_readdata <= {16'h0000, ctrl_r & TBC_CTRL_WMASK};
			end else if (idx == TBC_IDX_COUNT) begin
				avs_readdata <= {16'h0000, count_r};
			end else if (idx == TBC_IDX_RELOAD) begin
				avs_readdata <= {16'h0000, reload_r};
			end else if (idx == TBC_IDX_CAPTURE) begin
				avs_readdata <= {16'h0000, capture_r};
			end else if (idx == TBC_IDX_COMPARE) begin
				avs_readdata <= {16'h0000, compare_r};
			end else if (idx == TBC_IDX_IRQ_STATUS) begin
				avs_readdata <= {29'h0, irq_status_r};
			end else if (idx == TBC_IDX_IRQ_ENABLE) begin
				avs_readdata <= {29'h0, irq_enable_r};
			end else begin
				avs_readdata <= TBC_UNMAPPED_RD;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reload_r <= TBC_RELOAD_RST;
			compare_r <= TBC_COMPARE_RST;
			irq_enable_r <= TBC_IRQ_RST;
		end else if (bus_wr) begin
			if (idx == TBC_IDX_RELOAD) begin
				reload_r <= be_merge(reload_r, avs_req.writedata, avs_req.byteenable);
			end else if (idx == TBC_IDX_COMPARE) begin
				compare_r <= be_merge(compare_r, avs_req.writedata, avs_req.byteenable);
			end else if (idx == TBC_IDX_IRQ_ENABLE && avs_req.byteenable[0]) begin
				irq_enable_r <= avs_req.writedata[TBC_IRQ_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	// trigger capture and reload gating
	assign ext_capture = ctrl_r.capture_reload_select & ctrl_r.external_trigger_enable & ext_fall;
	assign ext_reload = ~ctrl_r.capture_reload_select & ctrl_r.external_trigger_enable & ext_fall
		& ~ctrl_r.down_count_enable & ~ctrl_r.pwm_enable;
	// in pin-directed up/down reload mode the trigger flag acts as a 17th count bit
	assign bit17_mode = ~ctrl_r.capture_reload_select & ctrl_r.down_count_enable & ~ctrl_r.pwm_enable;
	assign top = reload_r;

	always_comb begin
		if (ctrl_r.pwm_enable) begin
			dir_up = ctrl_r.down_count_enable ? pwm_dir_r : 1'b1;
		end else begin
			dir_up = ctrl_r.down_count_enable ? trig_s : 1'b1;
		end
	end

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	always_comb begin
		count_nxt = count_r;
		pwm_dir_nxt = pwm_dir_r;
		wrap = 1'b0;
		if (ext_reload) begin
			count_nxt = TBC_COUNT_ZERO;
		end else if (tick && ctrl_r.timer_run) begin
			if (ctrl_r.pwm_enable && !ctrl_r.down_count_enable) begin
				if (count_r >= top) begin
					count_nxt = TBC_COUNT_ZERO;
					wrap = 1'b1;
				end else begin
					count_nxt = count_r + 16'h0001;
				end
			end else if (ctrl_r.pwm_enable) begin
				if (dir_up && count_r >= top) begin
					count_nxt = (count_r == TBC_COUNT_ZERO) ? TBC_COUNT_ZERO : count_r - 16'h0001;
					pwm_dir_nxt = 1'b0;
					wrap = 1'b1;
				end else if (!dir_up && count_r == TBC_COUNT_ZERO) begin
					count_nxt = count_r + 16'h0001;
					pwm_dir_nxt = 1'b1;
				end else if (dir_up) begin
					count_nxt = count_r + 16'h0001;
				end else begin
					count_nxt = count_r - 16'h0001;
				end
			end else if (dir_up) begin
				if (count_r == TBC_COUNT_TOP) begin
					count_nxt = reload_r;
					wrap = 1'b1;
				end else begin
					count_nxt = count_r + 16'h0001;
				end
			end else begin
				if (count_r == TBC_COUNT_ZERO) begin
					count_nxt = reload_r;
					wrap = 1'b1;
				end else begin
					count_nxt = count_r - 16'h0001;
				end
			end
		end
		if (cnt_wr) begin
			count_nxt = be_merge(count_r, avs_req.writedata, avs_req.byteenable);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count_r <= TBC_COUNT_RST;
			pwm_dir_r <= 1'b1;
		end else begin
			count_r <= count_nxt;
			pwm_dir_r <= ctrl_r.pwm_enable ? pwm_dir_nxt : 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			capture_r <= TBC_COUNT_ZERO;
		end else if (ext_capture) begin
			capture_r <= count_r;
		end
	end

	// ------------------------------------------------------------
	// output pin: PWM level or clock output
	// ------------------------------------------------------------
	always_comb begin
		if (ctrl_r.pwm_enable) begin
			pin_nxt = count_nxt < compare_r;
		end else if (ctrl_r.clock_output_enable) begin
			pin_nxt = wrap ? ~pin_r : pin_r;
		end else begin
			pin_nxt = 1'b0;
		end
	end

	assign pwm_fall = ctrl_r.pwm_enable & pin_r & ~pin_nxt;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_r <= 1'b0;
			timer_output_pin_oe <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
			timer_output_pin_oe <= ctrl_r.pwm_enable | ctrl_r.clock_output_enable;
		end
	end

	assign timer_output_pin = pin_r;

	// ------------------------------------------------------------
	// control register and flags; hardware set wins over a software clear
	// ------------------------------------------------------------
	// trigger flag set: trigger capture/reload edge or PWM falling edge
	assign ext_set = (ext_capture | ext_reload) | (pwm_fall & ctrl_r.external_trigger_enable
		& ~ctrl_r.capture_reload_select);

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr) begin
			ctrl_nxt = be_merge(ctrl_r, avs_req.writedata, avs_req.byteenable) & TBC_CTRL_WMASK;
		end
		if (wrap) begin
			ctrl_nxt.overflow_flag = 1'b1;
		end
		if (bit17_mode && wrap) begin
			ctrl_nxt.external_trigger_flag = ~ctrl_r.external_trigger_flag;
		end else if (ext_set) begin
			ctrl_nxt.external_trigger_flag = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_r <= TBC_CTRL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	// timer request
	assign tmr_req = ctrl_r.timer_irq_enable & ((ctrl_r.overflow_flag & ~ctrl_r.clock_output_enable)
		| (ctrl_r.external_trigger_flag & ~bit17_mode));

	always_comb begin
		irq_status_nxt = irq_status_r;
		if (bus_wr && idx == TBC_IDX_IRQ_CLEAR && avs_req.byteenable[0]) begin
			irq_status_nxt = irq_status_r & ~avs_req.writedata[TBC_IRQ_W-1:0];
		end
		irq_status_nxt[TBC_IRQ_TIMER] = irq_status_nxt[TBC_IRQ_TIMER] | tmr_req;
		irq_status_nxt[TBC_IRQ_CAPTURE] = irq_status_nxt[TBC_IRQ_CAPTURE] | ext_capture;
		irq_status_nxt[TBC_IRQ_WRAP] = irq_status_nxt[TBC_IRQ_WRAP] | wrap | ext_reload;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_status_r <= TBC_IRQ_RST;
			irq <= 1'b0;
		end else begin
			irq_status_r <= irq_status_nxt;
			irq <= |(irq_status_nxt & irq_enable_r);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	ctrl_cleared_a: assert property (@(posedge mclk) $fell(rst) |-> ctrl_r == TBC_CTRL_RST)
		else $error("control word not zero after reset");
	capture_value_a: assert property (@(posedge mclk) disable iff (rst)
		ext_capture |=> capture_r == $past(count_r))
		else $error("capture did not take the count");
	ext_reload_zero_a: assert property (@(posedge mclk) disable iff (rst)
		(ext_reload && !cnt_wr) |=> count_r == TBC_COUNT_ZERO && ctrl_r.external_trigger_flag)
		else $error("trigger reload did not zero the count");
	overflow_reload_a: assert property (@(posedge mclk) disable iff (rst)
		(tick && ctrl_r.timer_run && !ctrl_r.pwm_enable && dir_up && count_r == TBC_COUNT_TOP
		&& !ext_reload && !cnt_wr) |=> count_r == $past(reload_r) && ctrl_r.overflow_flag)
		else $error("overflow did not reload");
	halt_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(!ctrl_r.timer_run && !ext_reload && !cnt_wr) |=> $stable(count_r))
		else $error("count moved while halted");
	ext_ignored_a: assert property (@(posedge mclk) disable iff (rst)
		!ctrl_r.external_trigger_enable |=> $stable(capture_r))
		else $error("trigger acted while disabled");
	irq_request_a: assert property (@(posedge mclk) disable iff (rst)
		(tmr_req && irq_enable_r[TBC_IRQ_TIMER]) |=> irq_status_r[TBC_IRQ_TIMER] && irq)
		else $error("timer request did not raise the interrupt");
	clkout_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		(ctrl_r.clock_output_enable && !ctrl_r.external_trigger_flag) |-> !tmr_req)
		else $error("overflow interrupted in clock-output mode");
	up_only_a: assert property (@(posedge mclk) disable iff (rst)
		(tick && ctrl_r.timer_run && !ctrl_r.down_count_enable && !ctrl_r.pwm_enable
		&& count_r != TBC_COUNT_TOP && !ext_reload && !cnt_wr) |=> count_r == $past(count_r) + 16'h0001)
		else $error("count did not step up");
	pin_down_a: assert property (@(posedge mclk) disable iff (rst)
		(tick && ctrl_r.timer_run && ctrl_r.down_count_enable && !ctrl_r.pwm_enable && !trig_s
		&& count_r != TBC_COUNT_ZERO && !cnt_wr) |=> count_r == $past(count_r) - 16'h0001)
		else $error("count did not step down with input low");
	compare_reset_a: assert property (@(posedge mclk) disable iff (rst)
		(tick && ctrl_r.timer_run && ctrl_r.pwm_enable && !ctrl_r.down_count_enable
		&& count_r >= top && !cnt_wr) |=> count_r == TBC_COUNT_ZERO)
		else $error("compare mode did not reset at top");
	pwm_turn_a: assert property (@(posedge mclk) disable iff (rst)
		(tick && ctrl_r.timer_run && ctrl_r.pwm_enable && ctrl_r.down_count_enable && pwm_dir_r
		&& count_r >= top && !ctrl_wr) |=> !pwm_dir_r)
		else $error("up/down PWM did not turn at top");
	pwm_edge_flag_a: assert property (@(posedge mclk) disable iff (rst)
		(pwm_fall && ctrl_r.external_trigger_enable && !ctrl_r.capture_reload_select
		&& !bit17_mode) |=> ctrl_r.external_trigger_flag)
		else $error("PWM falling edge missed the flag");
	ext_sticky_a: assert property (@(posedge mclk) disable iff (rst)
		(ctrl_r.external_trigger_flag && !ctrl_wr && !bit17_mode) |=> ctrl_r.external_trigger_flag)
		else $error("trigger flag cleared without software");

	capture_seen_c: cover property (@(posedge mclk) disable iff (rst) ext_capture);
	overflow_seen_c: cover property (@(posedge mclk) disable iff (rst) wrap && !ctrl_r.pwm_enable);
	pwm_fall_c: cover property (@(posedge mclk) disable iff (rst) pwm_fall);
	irq_seen_c: cover property (@(posedge mclk) disable iff (rst) $rose(irq));
endmodule

// [testbench/tbc_timer_tb.sv]
// tbc_timer_tb: register-level tests of the timer over Avalon-MM
// assumes one wait cycle per access and a pin model on the trigger input
`timescale 1ns/1ps

module tbc_timer_tb;
	import tbc_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	tbc_avs_req_s avs_req = '0;
	logic [TBC_DATA_W-1:0] avs_readdata;
	logic avs_waitrequest;
	logic level_req = 1'b1;
	logic trig_pin;
	logic timer_output_pin;
	logic timer_output_pin_oe;
	logic irq;
	int num_errors = 0;
	int tests_run = 0;
	logic [31:0] rdata;

	always #5 mclk = ~mclk;

	tbc_timer i_tbc_timer (.mclk(mclk), .rst(rst), .avs_req(avs_req), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trigger_direction_input(trig_pin),
		.timer_output_pin(timer_output_pin), .timer_output_pin_oe(timer_output_pin_oe), .irq(irq));
	tbc_trig_model i_tbc_trig_model (.mclk(mclk), .rst(rst), .level_req(level_req), .pin(trig_pin));

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	function automatic logic [7:0] ba(input logic [5:0] idx);
		return {idx, 2'b00};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// waitrequest is read right after the edge, so it is the value sampled at that edge
	// no local limit: a hung slave is caught by the watchdog
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_req.address <= a;
		avs_req.read <= !wr;
		avs_req.write <= wr;
		avs_req.byteenable <= 4'hF;
		avs_req.writedata <= d;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge mclk);
		end
		rdata = avs_readdata;
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [31:0] d);
		bus(1'b1, ba(idx), d);
	endtask

	task automatic rd(input logic [5:0] idx);
		bus(1'b0, ba(idx), 32'h0);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// one falling then rising edge on the trigger pin
	task automatic pulse();
		level_req <= 1'b0;
		cyc(10);
		level_req <= 1'b1;
		cyc(10);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		cyc(20000);
		num_errors++;
		close_out();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		cyc(6);
		rst <= 1'b0;
		rd(TBC_IDX_CTRL); check(rdata, 32'h0000);
		bus(1'b0, 8'hFC, 32'h0); check(rdata, TBC_UNMAPPED_RD);
		$display("test reset done");

		wr(TBC_IDX_COUNT, 32'h0100);
		wr(TBC_IDX_CTRL, 32'h0004);
		cyc(20);
		wr(TBC_IDX_CTRL, 32'h0000);
		rd(TBC_IDX_COUNT); check(rdata > 32'h0110, 1'b1);
		cyc(20);
		check(rdata < 32'h0120, 1'b1);
		begin
			logic [31:0] held;
			held = rdata;
			rd(TBC_IDX_COUNT); check(rdata, held);
		end
		$display("test run done");

		wr(TBC_IDX_RELOAD, 32'h1000);
		wr(TBC_IDX_COUNT, 32'hFFF0);
		wr(TBC_IDX_CTRL, 32'h0004);
		cyc(40);
		rd(TBC_IDX_CTRL); check(rdata[7], 1'b1);
		wr(TBC_IDX_CTRL, 32'h0000);
		rd(TBC_IDX_COUNT); check(rdata >= 32'h1000 && rdata < 32'h1100, 1'b1);
		$display("test reload done");

		wr(TBC_IDX_IRQ_ENABLE, 32'h1);
		wr(TBC_IDX_COUNT, 32'hFFF0);
		wr(TBC_IDX_CTRL, 32'h0006);
		cyc(40);
		check(irq, 1'b1);
		rd(TBC_IDX_IRQ_STATUS); check(rdata[0], 1'b1);
		wr(TBC_IDX_CTRL, 32'h0000);
		wr(TBC_IDX_IRQ_CLEAR, 32'h7);
		cyc(3);
		check(irq, 1'b0);
		wr(TBC_IDX_CTRL, 32'h0042);
		cyc(3);
		check(irq, 1'b1);
		wr(TBC_IDX_CTRL, 32'h0000);
		wr(TBC_IDX_IRQ_CLEAR, 32'h7);
		$display("test irq done");

		wr(TBC_IDX_COUNT, 32'hFFF0);
		wr(TBC_IDX_CTRL, 32'h0026);
		cyc(40);
		rd(TBC_IDX_CTRL); check(rdata[7], 1'b1);
		check(irq, 1'b0);
		check(timer_output_pin_oe, 1'b1);
		check(timer_output_pin, 1'b1);
		wr(TBC_IDX_CTRL, 32'h0000);
		wr(TBC_IDX_IRQ_CLEAR, 32'h7);
		$display("test clkout done");

		// timer stopped: trigger edges act with run clear
		wr(TBC_IDX_COUNT, 32'h0055);
		wr(TBC_IDX_CTRL, 32'h0000);
		pulse();
		rd(TBC_IDX_COUNT); check(rdata, 32'h0055);
		wr(TBC_IDX_CTRL, 32'h0008);
		pulse();
		rd(TBC_IDX_COUNT); check(rdata, 32'h0000);
		rd(TBC_IDX_CTRL); check(rdata[6], 1'b1);
		cyc(10);
		rd(TBC_IDX_CTRL); check(rdata[6], 1'b1);
		// capture mode: a trigger edge copies the held count into capture
		wr(TBC_IDX_COUNT, 32'h0077);
		wr(TBC_IDX_CTRL, 32'h0009);
		pulse();
		rd(TBC_IDX_CAPTURE); check(rdata, 32'h0077);
		wr(TBC_IDX_CTRL, 32'h0000);
		$display("test trigger done");

		level_req <= 1'b0;
		cyc(10);
		wr(TBC_IDX_COUNT, 32'h0100);
		wr(TBC_IDX_CTRL, 32'h0014);
		cyc(20);
		wr(TBC_IDX_CTRL, 32'h0000);
		rd(TBC_IDX_COUNT); check(rdata < 32'h0100, 1'b1);
		wr(TBC_IDX_COUNT, 32'h0100);
		wr(TBC_IDX_CTRL, 32'h0004);
		cyc(20);
		wr(TBC_IDX_CTRL, 32'h0000);
		rd(TBC_IDX_COUNT); check(rdata > 32'h0100, 1'b1);
		level_req <= 1'b1;
		cyc(10);
		wr(TBC_IDX_COUNT, 32'h0100);
		wr(TBC_IDX_CTRL, 32'h0014);
		cyc(20);
		wr(TBC_IDX_CTRL, 32'h0000);
		rd(TBC_IDX_COUNT); check(rdata > 32'h0100, 1'b1);
		$display("test direction done");

		// pwm: top 0x10, pin high below 0x08, trigger enable lets pin falls set the flag
		wr(TBC_IDX_RELOAD, 32'h0010);
		wr(TBC_IDX_COMPARE, 32'h0008);
		wr(TBC_IDX_COUNT, 32'h0000);
		wr(TBC_IDX_CTRL, 32'h080C);
		cyc(40);
		rd(TBC_IDX_CTRL); check(rdata[6], 1'b1);
		check(rdata[7], 1'b1);
		wr(TBC_IDX_CTRL, 32'h081C);
		cyc(40);
		wr(TBC_IDX_CTRL, 32'h0000);
		rd(TBC_IDX_COUNT); check(rdata <= 32'h0010, 1'b1);
		$display("test pwm done");

		// divide by four: about ten steps in forty cycles
		wr(TBC_IDX_COUNT, 32'h0000);
		wr(TBC_IDX_CTRL, 32'h0104);
		cyc(40);
		wr(TBC_IDX_CTRL, 32'h0000);
		rd(TBC_IDX_COUNT); check(rdata >= 32'h0008 && rdata <= 32'h000C, 1'b1);
		$display("test prescale done");

		wr(TBC_IDX_CTRL, 32'h0006);
		rst <= 1'b1;
		cyc(6);
		rst <= 1'b0;
		rd(TBC_IDX_CTRL); check(rdata, 32'h0000);
		$display("test second reset done");
		close_out();
	end
endmodule

// [testbench/tbc_trig_model.sv]
// tbc_trig_model: drives the trigger/direction pin seen by the timer
// assumes the bench asks for a level and holds it for several mclk cycles
`timescale 1ns/1ps

module tbc_trig_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic level_req,
	output logic pin
);
	// ----------------------------------------
	// pin driver
	// ----------------------------------------
	int unsigned hold_r;

	// level held as direction
	// the pin idles high so that the first low is a clean falling edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin <= 1'b1;
			hold_r <= 0;
		end else if (level_req != pin && hold_r >= 2) begin
			pin <= level_req;
			hold_r <= 0;
		end else begin
			hold_r <= hold_r + 1;
		end
	end
endmodule
